/* hw/ida_pkg.sv */
// constants and carrier types of the indirect data addressing unit
// Function
// RULE1 - plain access addresses at pointer, pointer unchanged
// RULE2 - post variants address, then step pointer
// RULE3 - pre-increment steps pointer, then addresses
// RULE4 - select bit 0 reaches default register
// RULE5 - select bit 1 reaches alternate register
// RULE6 - offset variant adds working register, pointer kept
package ida_pkg;
   // ************************************************************
   // widths and register map
   // ************************************************************
   localparam int PTR_W      = 12;
   localparam int PTR_HI_W   = 4;
   localparam int BANK_W     = 4;
   localparam int NUM_PTR    = 3;
   localparam logic [7:0] OFS_PTR0_LO = 8'h00;
   localparam logic [7:0] OFS_PTR0_HI = 8'h04;
   localparam logic [7:0] OFS_PTR1_LO = 8'h08;
   localparam logic [7:0] OFS_PTR1_HI = 8'h0c;
   localparam logic [7:0] OFS_PTR2_LO = 8'h10;
   localparam logic [7:0] OFS_PTR2_HI = 8'h14;
   localparam logic [7:0] OFS_WORKING = 8'h18;
   localparam logic [7:0] OFS_BANK    = 8'h1c;
   localparam logic [7:0] OFS_WDTCTRL = 8'h20;
   localparam logic [7:0] OFS_LASTADR = 8'h24;
   // watchdog control field positions
   localparam int WDT_REGSLP_BIT = 7;
   localparam int WDT_SHARED_BIT = 4;
   localparam int WDT_SWDTEN_BIT = 0;
   // reset values and bus response codes
   localparam logic [PTR_W-1:0]  PTR_RST  = 12'h000;
   localparam logic [7:0]        WORKING_REGISTER_RST = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
   localparam logic [1:0]        RESP_OKAY   = 2'h0;
   localparam logic [1:0]        RESP_SLVERR = 2'h2;

   // ************************************************************
   // access modes of the virtual indirect registers
   // ************************************************************
   typedef enum logic [2:0] {
      IDA_PLAIN,
      IDA_POSTINC,
      IDA_POSTDEC,
      IDA_PREINC,
      IDA_PLUSW
   } ida_mode_t;

   // core request: one access in every cycle that valid is high and sel is not 3
   typedef struct packed {
      logic            valid;
      logic [1:0]      sel;
      ida_mode_t       mode;
      logic            write;
      logic [7:0]      wdata;
   } ida_acc_t;

   // data memory request, registered
   typedef struct packed {
      logic             valid;
      logic             we;
      logic [PTR_W-1:0] addr;
      logic [7:0]       wdata;
   } ida_mem_t;

   // AXI4-Lite master to slave
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } ida_axi_req_t;

   // AXI4-Lite slave to master
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ida_axi_rsp_t;
endpackage

/* hw/ida_top.sv */
// indirect data addressing unit: pointers, virtual access, shared SFR select
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module ida_top
   import ida_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire ida_axi_req_t axiReq,
   output ida_axi_rsp_t      axiRsp,
   input  wire ida_acc_t     accReq,
   output ida_mem_t          memReq,
   input  wire logic         sharedHit,
   output logic              reachDefault,
   output logic              reachAlternate,
   output logic [BANK_W-1:0] bankSelect
);

   // ************************************************************
   // parameter check
   // ************************************************************
   // refused at elaboration: the offsets and the read mux assume an 8-bit bus address
   if (ADDR_W != 8) begin : g_bad_addr_w
      $error("ida_top: ADDR_W must be 8 to match the register map");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef logic [PTR_W-1:0] ida_ptr_t;

   typedef struct packed {
      ida_ptr_t [NUM_PTR-1:0] ptr;
      logic [7:0]             working_register;
      logic [BANK_W-1:0]      bank;
      logic                   regSlp;
      logic                   shared;
      logic                   swdten;
      logic                   awHeld;
      logic [7:0]             awAddr;
      logic                   wHeld;
      logic [7:0]             wData;
      logic                   wLane0;
      logic                   bValid;
      logic [1:0]             bResp;
      logic                   rValid;
      logic [31:0]            rData;
      logic [1:0]             rResp;
      ida_mem_t               mem;
      ida_ptr_t               lastAddr;
   } ida_state_t;

   ida_state_t st;
   ida_state_t next_st;

   // ************************************************************
   // address arithmetic
   // ************************************************************
   // address placed on data memory for a given mode
   function automatic ida_ptr_t ida_eff_addr(input ida_ptr_t p, input ida_mode_t m,
                                             input logic [7:0] w);
      ida_ptr_t a;
      a = p;
      unique case (m)
         IDA_PLAIN:   a = p;                       // RULE1
         IDA_POSTINC: a = p;                       // RULE2
         IDA_POSTDEC: a = p;                       // RULE2
         IDA_PREINC:  a = p + 12'h001;             // RULE3
         IDA_PLUSW:   a = p + {4'h0, w};           // RULE6
         default:     a = p;
      endcase
      return a;
   endfunction

   // pointer value left behind by an access
   function automatic ida_ptr_t ida_next_ptr(input ida_ptr_t p, input ida_mode_t m);
      ida_ptr_t n;
      n = p;
      unique case (m)
         IDA_PLAIN:   n = p;                       // RULE1
         IDA_POSTINC: n = p + 12'h001;             // RULE2
         IDA_POSTDEC: n = p - 12'h001;             // RULE2
         IDA_PREINC:  n = p + 12'h001;             // RULE3
         IDA_PLUSW:   n = p;                       // RULE6
         default:     n = p;
      endcase
      return n;
   endfunction

   // register read mux, unmapped offsets flagged
   function automatic logic [32:0] ida_read(input ida_state_t s, input logic [7:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      unique case (a)
         OFS_PTR0_LO: r = {1'b0, 24'h000000, s.ptr[0][7:0]};
         OFS_PTR0_HI: r = {1'b0, 28'h0000000, s.ptr[0][PTR_W-1:8]};
         OFS_PTR1_LO: r = {1'b0, 24'h000000, s.ptr[1][7:0]};
         OFS_PTR1_HI: r = {1'b0, 28'h0000000, s.ptr[1][PTR_W-1:8]};
         OFS_PTR2_LO: r = {1'b0, 24'h000000, s.ptr[2][7:0]};
         OFS_PTR2_HI: r = {1'b0, 28'h0000000, s.ptr[2][PTR_W-1:8]};
         OFS_WORKING: r = {1'b0, 24'h000000, s.working_register};
         OFS_BANK:    r = {1'b0, 28'h0000000, s.bank};
         OFS_WDTCTRL: r = {1'b0, 24'h000000, s.regSlp, 2'h0, s.shared, 3'h0, s.swdten};
         OFS_LASTADR: r = {1'b0, 20'h00000, s.lastAddr};
         default:     r = {1'b1, 32'h0000_0000};
      endcase
      return r;
   endfunction

   // ************************************************************
   // next-state logic
   // ************************************************************
   logic        doWrite;
   logic        hit;
   logic [32:0] rdMux;
   ida_ptr_t    selPtr;

   // core access first, so a bus write in the same cycle lands last and wins
   always_comb begin
      next_st = st;
      doWrite = 1'b0;
      hit     = 1'b1;
      rdMux   = 33'h0_0000_0000;
      // select 3 names no pointer; keep the index in range so the mux never reads off the end
      selPtr  = st.ptr[(accReq.sel == 2'h3) ? 2'h0 : accReq.sel];

      // memory request lasts one cycle per access
      next_st.mem.valid = 1'b0;
      if (accReq.valid && accReq.sel != 2'h3) begin
         next_st.mem.valid        = 1'b1;
         next_st.mem.we           = accReq.write;
         next_st.mem.wdata        = accReq.wdata;
         next_st.mem.addr         = ida_eff_addr(selPtr, accReq.mode, st.working_register);
         next_st.lastAddr         = ida_eff_addr(selPtr, accReq.mode, st.working_register);
         next_st.ptr[accReq.sel]  = ida_next_ptr(selPtr, accReq.mode);
      end

      // write address and data are taken in either order and held
      if (axiReq.awvalid && !st.awHeld && !st.bValid) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && !st.wHeld && !st.bValid) begin
         next_st.wHeld  = 1'b1;
         next_st.wData  = axiReq.wdata[7:0];
         next_st.wLane0 = axiReq.wstrb[0];
      end

      // both halves held: commit the write and answer
      if (st.awHeld && st.wHeld) begin
         doWrite        = st.wLane0;
         hit            = 1'b1;
         next_st.awHeld = 1'b0;
         next_st.wHeld  = 1'b0;
         next_st.bValid = 1'b1;
         unique case (st.awAddr)
            OFS_PTR0_LO: if (doWrite) next_st.ptr[0][7:0]       = st.wData;
            OFS_PTR0_HI: if (doWrite) next_st.ptr[0][PTR_W-1:8] = st.wData[PTR_HI_W-1:0];
            OFS_PTR1_LO: if (doWrite) next_st.ptr[1][7:0]       = st.wData;
            OFS_PTR1_HI: if (doWrite) next_st.ptr[1][PTR_W-1:8] = st.wData[PTR_HI_W-1:0];
            OFS_PTR2_LO: if (doWrite) next_st.ptr[2][7:0]       = st.wData;
            OFS_PTR2_HI: if (doWrite) next_st.ptr[2][PTR_W-1:8] = st.wData[PTR_HI_W-1:0];
            OFS_WORKING: if (doWrite) next_st.working_register              = st.wData;
            OFS_BANK:    if (doWrite) next_st.bank              = st.wData[BANK_W-1:0];
            OFS_WDTCTRL: begin
               if (doWrite) begin
                  next_st.regSlp = st.wData[WDT_REGSLP_BIT];
                  next_st.shared = st.wData[WDT_SHARED_BIT];
                  next_st.swdten = st.wData[WDT_SWDTEN_BIT];
               end
            end
            OFS_LASTADR: hit = 1'b1;                 // read-only, write ignored
            default:     hit = 1'b0;
         endcase
         next_st.bResp = hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (st.bValid && axiReq.bready) begin
         next_st.bValid = 1'b0;
      end

      // reads answer one cycle after the address is taken
      rdMux = ida_read(st, axiReq.araddr);
      if (axiReq.arvalid && !st.rValid) begin
         next_st.rValid = 1'b1;
         next_st.rData  = rdMux[31:0];
         next_st.rResp  = rdMux[32] ? RESP_SLVERR : RESP_OKAY;
      end else if (st.rValid && axiReq.rready) begin
         next_st.rValid = 1'b0;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st.ptr      <= {NUM_PTR{PTR_RST}};
         st.working_register     <= WORKING_REGISTER_RST;
         st.bank     <= BANK_RST;
         st.regSlp   <= 1'b0;
         st.shared   <= 1'b0;
         st.swdten   <= 1'b0;
         st.awHeld   <= 1'b0;
         st.awAddr   <= 8'h00;
         st.wHeld    <= 1'b0;
         st.wData    <= 8'h00;
         st.wLane0   <= 1'b0;
         st.bValid   <= 1'b0;
         st.bResp    <= RESP_OKAY;
         st.rValid   <= 1'b0;
         st.rData    <= 32'h0000_0000;
         st.rResp    <= RESP_OKAY;
         st.mem      <= '0;
         st.lastAddr <= PTR_RST;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // handshake readies are combinational; a held half blocks a second one
   always_comb begin
      axiRsp.awready = !st.awHeld && !st.bValid;
      axiRsp.wready  = !st.wHeld && !st.bValid;
      axiRsp.bvalid  = st.bValid;
      axiRsp.bresp   = st.bResp;
      axiRsp.arready = !st.rValid;
      axiRsp.rvalid  = st.rValid;
      axiRsp.rdata   = st.rData;
      axiRsp.rresp   = st.rResp;
   end

   assign memReq     = st.mem;
   assign bankSelect = st.bank;

   // overlapping SFR addresses steered by the shared select bit
   assign reachDefault   = sharedHit && !st.shared;  // RULE4
   assign reachAlternate = sharedHit && st.shared;   // RULE5

endmodule

/* tb/ida_top_properties.sv */
// port-level assertions of the indirect data addressing unit
`timescale 1ns/1ps
module ida_top_properties
   import ida_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic              clk,
   input wire logic              arst_n,
   input wire ida_axi_req_t      axiReq,
   input wire ida_axi_rsp_t      axiRsp,
   input wire ida_acc_t          accReq,
   input wire ida_mem_t          memReq,
   input wire logic              sharedHit,
   input wire logic              reachDefault,
   input wire logic              reachAlternate,
   input wire logic [BANK_W-1:0] bankSelect
);
   logic       quiet, take, takeQ, pair, selSeen;
   logic [1:0] selQ;
   ida_mode_t  modeQ;
   logic [7:0] awSeen;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // both write readies up: no bus write can commit at the next edge
   assign quiet = axiRsp.awready && axiRsp.wready;
   assign take  = accReq.valid && accReq.sel != 2'd3 && quiet;
   assign pair  = take && takeQ && accReq.sel == selQ;
   // previous access and last bus write, to judge pairs and commits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         takeQ   <= 1'b0;
         selQ    <= 2'd0;
         modeQ   <= IDA_PLAIN;
         awSeen  <= 8'h00;
         selSeen <= 1'b0;
      end else begin
         takeQ <= take;
         selQ  <= accReq.sel;
         modeQ <= accReq.mode;
         if (axiReq.awvalid && axiRsp.awready) awSeen <= axiReq.awaddr;
         if (axiReq.wvalid && axiRsp.wready) selSeen <= axiReq.wdata[WDT_SHARED_BIT];
      end
   end
   // ****
   // core access path
   // ****
   chk_pulse_next: assert property (accReq.valid && accReq.sel != 2'd3 |=> memReq.valid)
      else $error("access gave no memory request");
   chk_no_spurious: assert property (!(accReq.valid && accReq.sel != 2'd3) |=> !memReq.valid)
      else $error("memory request without access");
   chk_plain_keep: assert property (pair && modeQ == IDA_PLAIN && accReq.mode == IDA_PLAIN
      |=> memReq.addr == $past(memReq.addr)) else $error("plain access moved pointer");
   chk_post_inc: assert property (pair && modeQ == IDA_POSTINC && accReq.mode == IDA_PLAIN
      |=> memReq.addr - $past(memReq.addr) == 12'h001) else $error("post increment wrong");
   chk_post_dec: assert property (pair && modeQ == IDA_POSTDEC && accReq.mode == IDA_PLAIN
      |=> memReq.addr - $past(memReq.addr) == 12'hfff) else $error("post decrement wrong");
   chk_pre_inc: assert property (pair && modeQ == IDA_PLAIN && accReq.mode == IDA_PREINC
      |=> memReq.addr - $past(memReq.addr) == 12'h001) else $error("pre increment wrong");
   chk_offset_keep: assert property (pair && modeQ == IDA_PLAIN && accReq.mode == IDA_PLUSW
      ##1 pair && accReq.mode == IDA_PLAIN |=> memReq.addr == $past(memReq.addr, 2))
      else $error("offset access moved pointer");
   // ****
   // shared address select
   // ****
   chk_reach_default: assert property ($rose(axiRsp.bvalid) && awSeen == OFS_WDTCTRL
      && !selSeen |-> reachDefault == sharedHit && !reachAlternate)
      else $error("default register not reached");
   chk_reach_alt: assert property ($rose(axiRsp.bvalid) && awSeen == OFS_WDTCTRL
      && selSeen |-> reachAlternate == sharedHit && !reachDefault)
      else $error("alternate register not reached");
endmodule
bind ida_top ida_top_properties #(.ADDR_W(ADDR_W)) i_props (.clk(clk), .arst_n(arst_n),
   .axiReq(axiReq), .axiRsp(axiRsp), .accReq(accReq), .memReq(memReq), .sharedHit(sharedHit),
   .reachDefault(reachDefault), .reachAlternate(reachAlternate), .bankSelect(bankSelect));

/* tb/ida_mem_model.sv */
// data memory on the far side of the addressing unit
`timescale 1ns/1ps
module ida_mem_model
   import ida_pkg::*;
(
   input wire logic     clk,
   input wire ida_mem_t memReq,
   output logic [7:0]   rdByte
);
   logic [7:0] mem [4096];
   // stores only on a write pulse; reads show the addressed byte
   always @(posedge clk) begin
      if (memReq.valid && memReq.we) mem[memReq.addr] <= memReq.wdata;
   end
   assign rdByte = mem[memReq.addr];
endmodule

/* tb/testbench.sv */
// self-checking bench of the indirect data addressing unit
`timescale 1ns/1ps
module testbench
   import ida_pkg::*;
;
   logic         clk, arst_n, sharedHit, reachDefault, reachAlternate;
   ida_axi_req_t axiReq;
   ida_axi_rsp_t axiRsp;
   ida_acc_t     accReq;
   ida_mem_t     memReq;
   logic [3:0]   bankSelect;
   logic [11:0]  ptr [3];
   logic [7:0]   wk;
   logic [3:0]   bk;
   logic [11:0]  lastA;
   logic [20:0]  accQ [$];
   logic [33:0]  rdQ [$];
   int           err_total, compares;

   ida_top #(.ADDR_W(8)) i_dut (.clk(clk), .arst_n(arst_n), .axiReq(axiReq), .axiRsp(axiRsp),
      .accReq(accReq), .memReq(memReq), .sharedHit(sharedHit), .reachDefault(reachDefault),
      .reachAlternate(reachAlternate), .bankSelect(bankSelect));
   ida_mem_model i_mem (.clk(clk), .memReq(memReq), .rdByte());

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
      compares++;
      if (e !== s) begin
         err_total++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 64) begin
         err_total++;
         tally_and_finish;
      end
   endtask
   // ****
   // register bus master; bready and rready stay high throughout
   // ****
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      bit aw, w;
      n = 0;
      {aw, w} = 2'b00;
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr  <= a;
      axiReq.wvalid  <= 1'b1;
      axiReq.wdata   <= d;
      while (!(aw && w)) begin
         tick(n);
         // local flags change at once; the bus signals drop after the taking edge
         if (!aw && axiRsp.awready) begin
            aw = 1'b1;
            axiReq.awvalid <= 1'b0;
         end
         if (!w && axiRsp.wready) begin
            w = 1'b1;
            axiReq.wvalid <= 1'b0;
         end
      end
      while (!axiRsp.bvalid) tick(n);
      chk("bresp", 34'(RESP_OKAY), 34'(axiRsp.bresp));
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      n = 0;
      rdQ.push_back(e);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr  <= a;
      do tick(n); while (!axiRsp.arready);
      axiReq.arvalid <= 1'b0;
      do tick(n); while (!axiRsp.rvalid);
   endtask
   // core access; the caller drops valid after the last one
   task automatic acc(input logic [1:0] s, input ida_mode_t m, input logic we);
      logic [11:0] a;
      logic [7:0]  d;
      d = 8'($urandom);
      if (s != 2'd3) begin
         a = ptr[s];
         case (m)
            IDA_POSTINC: ptr[s] = a + 12'h001;
            IDA_POSTDEC: ptr[s] = a - 12'h001;
            IDA_PREINC: begin
               ptr[s] = a + 12'h001;
               a      = ptr[s];
            end
            IDA_PLUSW: a = a + {4'h0, wk};
            default: ;
         endcase
         accQ.push_back({we, a, we ? d : 8'h00});
         lastA = a;
      end
      accReq <= '{1'b1, s, m, we, d};
      @(posedge clk);
   endtask
   // monitor: each result takes the oldest note; an unnoted request fails
   always @(posedge clk) begin
      if (memReq.valid) chk("memreq", accQ.size() > 0 ? 34'(accQ.pop_front()) : 'x,
         34'({memReq.we, memReq.addr, memReq.we ? memReq.wdata : 8'h00}));
      if (axiRsp.rvalid && axiReq.rready) chk("rdata", rdQ.pop_front(), {axiRsp.rresp, axiRsp.rdata});
   end

   initial begin
      axiReq = '0;
      axiReq.wstrb  = 4'hf;
      axiReq.bready = 1'b1;
      axiReq.rready = 1'b1;
      accReq = '0;
      {sharedHit, arst_n, err_total, compares} = '0;
      void'($urandom(32'h9dd9));
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 10; i++) rd(8'(4 * i), 34'h0);
      rd(8'h28, {RESP_SLVERR, 32'h0});
      $display("test reset values done");
      wk = 8'($urandom);
      wr(OFS_WORKING, {24'h0, wk});
      // bank select register must show on its output pins as well as on the bus
      bk = 4'($urandom);
      wr(OFS_BANK, {28'h0, bk});
      chk("bank", 34'(bk), 34'(bankSelect));
      rd(OFS_BANK, {2'b00, 28'h0, bk});
      ptr = '{12'h0ff, 12'h000, 12'hfff};
      for (int s = 0; s < 3; s++) begin
         wr(8'(8 * s), {24'h0, ptr[s][7:0]});
         wr(8'(8 * s + 4), {28'h0, ptr[s][11:8]});
      end
      for (int s = 0; s < 3; s++) begin
         for (int m = 4; m >= 0; m--) begin
            acc(2'(s), IDA_PLAIN, 1'b0);
            acc(2'(s), ida_mode_t'(m), 1'b1);
            acc(2'(s), IDA_PLAIN, 1'b1);
         end
      end
      for (int i = 0; i < 60; i++) begin
         acc(2'($urandom_range(3)), ida_mode_t'($urandom_range(4)), 1'($urandom));
      end
      accReq.valid <= 1'b0;
      @(posedge clk);
      for (int s = 0; s < 3; s++) begin
         rd(8'(8 * s), {2'b00, 24'h0, ptr[s][7:0]});
         rd(8'(8 * s + 4), {2'b00, 28'h0, ptr[s][11:8]});
      end
      // last effective address is read-only: a write must leave it alone
      wr(OFS_LASTADR, 32'h0000_0fff ^ {20'h0, lastA});
      rd(OFS_LASTADR, {2'b00, 20'h0, lastA});
      $display("test indirect modes done");
      for (int b = 0; b < 2; b++) begin
         wr(OFS_WDTCTRL, 32'(b) << WDT_SHARED_BIT);
         rd(OFS_WDTCTRL, 34'(b) << WDT_SHARED_BIT);
         for (int h = 0; h < 2; h++) begin
            sharedHit <= 1'(h);
            @(posedge clk);
            chk("default", 34'(h == 1 && b == 0), 34'(reachDefault));
            chk("alternate", 34'(h == 1 && b == 1), 34'(reachAlternate));
         end
      end
      $display("test shared select done");
      // reset in mid-run: select bit and pointers fall back to zero
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk("default", 34'h1, 34'(reachDefault));
      chk("alternate", 34'h0, 34'(reachAlternate));
      rd(OFS_WDTCTRL, 34'h0);
      rd(OFS_PTR1_LO, 34'h0);
      $display("test reset mid-run done");
      repeat (3) @(posedge clk);
      tally_and_finish;
   end
endmodule
